// file: rtl/fault_frame.sv
// fault capture, frame contents and exception-return recovery
// assumes core sequencer supplies fault events and frame data as pulses
`timescale 1ns/100ps
module fault_frame
   import fault_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic ce,
   // fault event
   input wire logic fault,
   input wire logic released_write,
   input wire logic in_move_xfer,
   input wire logic in_exception,
   input wire logic exc_is_bus_fault,
   input wire logic exc_short_frame,
   input wire logic locked,
   input wire logic is_read,
   input wire logic restart_fetch,
   input wire logic long_half,
   input wire logic [1:0] size_left,
   input wire logic [2:0] space,
   input wire logic step_pend,
   input wire logic ebrk_pend,
   input wire logic ibrk_pend,
   input wire logic [31:0] fault_addr,
   input wire logic [31:0] out_data,
   input wire logic [31:0] pc,
   input wire logic [15:0] status,
   // move progress
   input wire logic [4:0] move_attempted,
   input wire logic [31:0] move_addr,
   input wire logic move_predec,
   input wire logic move_done,
   input wire logic [31:0] postinc_val,
   // faulted exception frame
   input wire logic [15:0] exc_status,
   input wire logic [15:0] exc_vector,
   input wire logic [31:0] exc_pc,
   input wire logic [31:0] exc_ret,
   // exception return
   input wire logic ret_go,
   input wire logic [15:0] ret_word,
   input wire logic [31:0] ret_addr,
   input wire logic [31:0] ret_data,
   input wire logic [31:0] ret_pc,
   input wire logic [15:0] ret_status,
   input wire logic rerun_ack,
   input wire logic [31:0] rerun_rdata,
   // frame outputs
   output logic frame_valid,
   output logic [15:0] frame_word,
   output logic [31:0] frame_addr,
   output logic [31:0] frame_data,
   output logic [31:0] frame_pc,
   output logic [15:0] frame_status,
   output logic [7:0] frame_count,
   output logic frame_below,
   output logic [15:0] frame_exc_status,
   output logic [15:0] frame_exc_vector,
   output logic [31:0] frame_exc_pc,
   output logic [31:0] frame_exc_ret,
   output logic restore_regs,
   output logic postinc_we,
   output logic [31:0] postinc_out,
   output logic halted,
   // return outputs
   output logic [31:0] rest_addr,
   output logic [31:0] rest_data,
   output logic [31:0] rest_pc,
   output logic [15:0] rest_status,
   output logic requeue_step,
   output logic requeue_ebrk,
   output logic requeue_ibrk,
   output logic rerun_req,
   output logic rerun_read,
   output logic [2:0] rerun_space,
   output logic [1:0] rerun_size,
   output logic [31:0] rerun_wdata,
   output logic refetch,
   output logic move_resume
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef enum logic [2:0] {
      ST_RUN = 3'h1, ST_RERUN = 3'h2, ST_HALT = 3'h4
   } st_t;
   typedef struct packed {
      st_t st;
      logic fv;
      logic [15:0] word;
      logic [31:0] addr;
      logic [31:0] data;
      logic [31:0] pc;
      logic [15:0] status;
      logic [7:0] cnt;
      logic below;
      logic [15:0] es;
      logic [15:0] ev;
      logic [31:0] epc;
      logic [31:0] eret;
      logic restore;
      logic piwe;
      logic [31:0] pival;
      logic [31:0] raddr;
      logic [31:0] rdata;
      logic [31:0] rpc;
      logic [15:0] rstat;
      logic rq_step;
      logic rq_eb;
      logic rq_ib;
      logic rr_read;
      logic [2:0] rr_space;
      logic [1:0] rr_size;
      logic refetch;
      logic resume;
   } state_t;
   state_t s_r, s_nxt;
   class_t cls; // classified fault
   logic [15:0] word_w; // encoded status word
   logic [7:0] cnt_w; // remaining transfers
   logic [31:0] next_w; // next move address
   logic [1:0] op_size; // whole operand size for the address step
   // ----------------------------------------
   // classification
   // ----------------------------------------
   always_comb begin
      if (in_exception) begin
         cls = CLS_EXCEPT;
      end else if (released_write) begin
         cls = CLS_WRITE;
      end else if (in_move_xfer) begin
         cls = CLS_MOVE;
      end else begin
         cls = CLS_RESTART; // opcode prefetch too
      end
   end
   // word encoder
   status_word_build u_word (
      .cls(cls),
      .step_pend(step_pend),
      .ebrk_pend(ebrk_pend),
      .ibrk_pend(ibrk_pend),
      .locked(locked),
      .is_read(is_read),
      .restart_fetch(restart_fetch),
      .long_half(long_half),
      .size_left(size_left),
      .space(space),
      .word(word_w)
   );
   // a long operand faulted on its second half still steps by a long
   assign op_size = long_half ? SIZE_LONG : size_left;
   // move arithmetic
   move_count u_cnt (
      .attempted(move_attempted),
      .op_addr(move_addr),
      .predec(move_predec),
      .size_code(op_size),
      .xfer_left(cnt_w),
      .next_addr(next_w)
   );
   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      s_nxt = s_r;
      s_nxt.fv = 1'b0;
      s_nxt.restore = 1'b0;
      s_nxt.piwe = 1'b0;
      s_nxt.rq_step = 1'b0;
      s_nxt.rq_eb = 1'b0;
      s_nxt.rq_ib = 1'b0;
      s_nxt.refetch = 1'b0;
      s_nxt.resume = 1'b0;
      case (s_r.st)
         ST_RUN: begin
            if (fault && in_exception && exc_is_bus_fault) begin
               s_nxt.st = ST_HALT;
            end else if (fault) begin
               s_nxt.fv = 1'b1;
               s_nxt.word = word_w;
               s_nxt.data = out_data;
               s_nxt.pc = pc;
               s_nxt.status = status;
               s_nxt.below = in_exception && exc_short_frame;
               s_nxt.es = exc_status;
               s_nxt.ev = exc_vector;
               s_nxt.epc = exc_pc;
               s_nxt.eret = exc_ret;
               // restartable faults undo address updates
               s_nxt.restore = (cls == CLS_RESTART);
               if (cls == CLS_MOVE) begin
                  s_nxt.addr = next_w;
                  s_nxt.cnt = cnt_w;
               end else begin
                  s_nxt.addr = fault_addr;
                  s_nxt.cnt = 8'h00;
               end
            end else if (move_done) begin
               s_nxt.piwe = 1'b1; // only at instruction end
               s_nxt.pival = postinc_val;
            end else if (ret_go) begin
               s_nxt.raddr = ret_addr;
               s_nxt.rdata = ret_data;
               s_nxt.rpc = ret_pc;
               s_nxt.rstat = ret_status;
               s_nxt.rq_step = ret_word[STEP_B];
               s_nxt.rq_eb = ret_word[EBRK_B];
               s_nxt.rq_ib = ret_word[IBRK_B];
               if (ret_word[RERUN_B]) begin
                  s_nxt.st = ST_RERUN;
                  s_nxt.rr_read = ret_word[READ_B];
                  s_nxt.rr_space = ret_word[SPACE_LO +: 3];
                  s_nxt.rr_size = ret_word[SIZE_LO +: 2];
               end else if (ret_word[MOVE_B]) begin
                  s_nxt.resume = 1'b1;
               end else if (!ret_word[KIND_B]) begin
                  s_nxt.refetch = 1'b1;
               end
            end
         end
         ST_RERUN: begin
            // read data, if any, is dropped
            if (rerun_ack) begin
               s_nxt.st = ST_RUN;
            end
         end
         ST_HALT: s_nxt.st = ST_HALT;
         default: s_nxt.st = ST_RUN;
      endcase
   end
   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         s_r <= '0;
         s_r.st <= ST_RUN;
      end else if (ce) begin
         s_r <= s_nxt;
      end
   end
   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign frame_valid = s_r.fv;
   assign frame_word = s_r.word;
   assign frame_addr = s_r.addr;
   assign frame_data = s_r.data;
   assign frame_pc = s_r.pc;
   assign frame_status = s_r.status;
   assign frame_count = s_r.cnt;
   assign frame_below = s_r.below;
   assign frame_exc_status = s_r.es;
   assign frame_exc_vector = s_r.ev;
   assign frame_exc_pc = s_r.epc;
   assign frame_exc_ret = s_r.eret;
   assign restore_regs = s_r.restore;
   assign postinc_we = s_r.piwe;
   assign postinc_out = s_r.pival;
   assign halted = (s_r.st == ST_HALT);
   assign rest_addr = s_r.raddr;
   assign rest_data = s_r.rdata;
   assign rest_pc = s_r.rpc;
   assign rest_status = s_r.rstat;
   assign requeue_step = s_r.rq_step;
   assign requeue_ebrk = s_r.rq_eb;
   assign requeue_ibrk = s_r.rq_ib;
   assign rerun_req = (s_r.st == ST_RERUN);
   assign rerun_read = s_r.rr_read;
   assign rerun_space = s_r.rr_space;
   assign rerun_size = s_r.rr_size;
   assign rerun_wdata = s_r.rdata;
   assign refetch = s_r.refetch;
   assign move_resume = s_r.resume;
   // ----------------------------------------
   // checks
   // ----------------------------------------
   a_restart_word: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      ce && s_r.st == ST_RUN && fault && cls == CLS_RESTART |=>
      frame_word[15:12] == 4'h0 && !frame_word[RERUN_B])
      else $error("restart word bits wrong");
   a_break_saved: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      ce && s_r.st == ST_RUN && fault && !(in_exception && exc_is_bus_fault)
      |=> frame_word[EBRK_B] == $past(ebrk_pend)
      && frame_word[IBRK_B] == $past(ibrk_pend))
      else $error("breakpoint bits lost");
   a_lock_read: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      ce && s_r.st == ST_RUN && fault && cls == CLS_RESTART |=>
      frame_word[LOCK_B] == $past(locked)
      && frame_word[READ_B] == $past(is_read))
      else $error("locked or read flag wrong");
   a_move_keep: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      ce && s_r.st == ST_RUN && fault && cls != CLS_RESTART |=>
      !restore_regs && !postinc_we)
      else $error("register restored after continuable fault");
   a_postinc_end: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      ce && s_r.st == ST_RUN && !fault && move_done |=>
      postinc_we && postinc_out == $past(postinc_val))
      else $error("postincrement not written at end");
   a_move_word: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      ce && s_r.st == ST_RUN && fault && cls == CLS_MOVE |=>
      frame_word[MOVE_B] && !frame_word[KIND_B] && !frame_word[LOCK_B]
      && frame_word[RERUN_B] == !$past(is_read))
      else $error("move word wrong");
   a_move_count: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      ce && s_r.st == ST_RUN && fault && cls == CLS_MOVE |=>
      frame_count == 8'(5'h10 - $past(move_attempted)))
      else $error("transfer count wrong");
   a_double_halt: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      ce && s_r.st == ST_RUN && fault && in_exception && exc_is_bus_fault
      |=> halted [*3])
      else $error("no halt on double fault");
   a_below_frame: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      ce && s_r.st == ST_RUN && fault && !(in_exception && exc_is_bus_fault)
      |=> frame_below == ($past(in_exception) && $past(exc_short_frame)))
      else $error("frame placement wrong");
   a_exc_word: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      ce && s_r.st == ST_RUN && fault && in_exception && !exc_is_bus_fault
      |=> frame_word[15:14] == 2'h2 && frame_word[9:6] == 4'h1)
      else $error("exception word wrong");
   a_rerun_start: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      ce && s_r.st == ST_RUN && ret_go && !fault && !move_done
      && ret_word[RERUN_B] |=> rerun_req
      && rerun_space == $past(ret_word[2:0]))
      else $error("rerun not started");
   a_rerun_hold: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      rerun_req |=> rest_data == $past(rest_data))
      else $error("rerun read data not dropped");
   a_restart_refetch: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      ce && s_r.st == ST_RUN && ret_go && !fault && !move_done
      && ret_word[15:14] == 2'h0 && !ret_word[RERUN_B] |=> refetch)
      else $error("restart frame not refetched");
   a_requeue: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      ce && s_r.st == ST_RUN && ret_go && !fault && !move_done |=>
      requeue_step == $past(ret_word[STEP_B]))
      else $error("step not requeued");
endmodule

// file: rtl/fault_pkg.sv
// fault frame constants shared by the fault capture and unstacking logic
// assumes a single core clock domain and active-low asynchronous reset
//
// Overview of operation
// - restartable fault clears kind, move, step, rerun
// - breakpoint pending bits always saved
// - locked cycle flagged; read flag picks half
// - move operand faults continuable; opcode prefetch restartable
// - continuable fault restores no altered register
// - postincrement register written only at instruction end
// - continuable move fault sets move flag, clears kind, locked
// - continuable prefetch flag only on restart fetch
// - continuable write fault sets rerun flag
// - fault address holds next advanced operand address
// - transfer counter is sixteen minus attempted
// - second fault while processing a bus fault exception halts
// - fault on short frame stacks beneath it
// - exception fault sets kind and read, keeps step; clears move, rerun, locked
// - exception fault stacks status, vector, addresses
// - second half of long sets long flag
// - return restores address, data, program counter, status
// - return requeues pending step and breakpoints
// - rerun flag reloads read, space, size; reruns
// - edited rerun read discards returned data
// - restartable frame refetches and restarts instruction
// - size codes long, byte, word; fourth reserved
// - read flag set on read, clear on write
// - space code copied into status word
package fault_pkg;
   // ----------------------------------------
   // status word field positions
   // ----------------------------------------
   localparam int KIND_B = 15;
   localparam int MOVE_B = 14;
   localparam int STEP_B = 12;
   localparam int EBRK_B = 11;
   localparam int IBRK_B = 10;
   localparam int RERUN_B = 9;
   localparam int LOCK_B = 8;
   localparam int PREF_B = 7;
   localparam int READ_B = 6;
   localparam int LONG_B = 5;
   localparam int SIZE_LO = 3;
   localparam int SPACE_LO = 0;
   // ----------------------------------------
   // size codes and counts
   // ----------------------------------------
   localparam logic [1:0] SIZE_LONG = 2'h0;
   localparam logic [1:0] SIZE_BYTE = 2'h1;
   localparam logic [1:0] SIZE_WORD = 2'h2;
   localparam logic [4:0] XFER_TOTAL = 5'h10;
   localparam logic [15:0] WORD_RST = 16'h0000;
   // fault classes
   typedef enum logic [3:0] {
      CLS_WRITE = 4'h1, CLS_RESTART = 4'h2,
      CLS_MOVE = 4'h4, CLS_EXCEPT = 4'h8
   } class_t;
endpackage

// file: rtl/status_word_build.sv
// status word builder: combinational encode of one fault
// assumes the caller registers the result
`timescale 1ns/100ps
module status_word_build
   import fault_pkg::*;
(
   // fault description
   input wire class_t cls,
   input wire logic step_pend,
   input wire logic ebrk_pend,
   input wire logic ibrk_pend,
   input wire logic locked,
   input wire logic is_read,
   input wire logic restart_fetch,
   input wire logic long_half,
   input wire logic [1:0] size_left,
   input wire logic [2:0] space,
   // encoded word
   output logic [15:0] word
);
   // ----------------------------------------
   // encode
   // ----------------------------------------
   always_comb begin
      word = WORD_RST;
      word[EBRK_B] = ebrk_pend;
      word[IBRK_B] = ibrk_pend;
      word[LONG_B] = long_half;
      word[SIZE_LO +: 2] = size_left;
      word[SPACE_LO +: 3] = space;
      case (cls)
         CLS_WRITE: begin
            word[STEP_B] = step_pend;
            word[RERUN_B] = 1'b1;
         end
         CLS_RESTART: begin
            // step cleared: instruction restarts
            word[LOCK_B] = locked;
            word[PREF_B] = restart_fetch;
            word[READ_B] = is_read;
         end
         CLS_MOVE: begin
            word[MOVE_B] = 1'b1;
            word[STEP_B] = step_pend;
            word[RERUN_B] = ~is_read;
            word[PREF_B] = restart_fetch;
            word[READ_B] = is_read;
         end
         CLS_EXCEPT: begin
            word[KIND_B] = 1'b1;
            word[STEP_B] = step_pend;
            word[READ_B] = 1'b1;
         end
         default: word = WORD_RST;
      endcase
   end
endmodule

// file: rtl/move_count.sv
// transfer counter and next operand address for a faulted register move
// assumes attempted count includes the faulted transfer
`timescale 1ns/100ps
module move_count
   import fault_pkg::*;
(
   // progress
   input wire logic [4:0] attempted,
   input wire logic [31:0] op_addr,
   input wire logic predec,
   input wire logic [1:0] size_code,
   // results
   output logic [7:0] xfer_left,
   output logic [31:0] next_addr
);
   // operand size in bytes
   function automatic logic [31:0] size_bytes(input logic [1:0] s);
      case (s)
         SIZE_BYTE: size_bytes = 32'h00000001;
         SIZE_WORD: size_bytes = 32'h00000002;
         default: size_bytes = 32'h00000004;
      endcase
   endfunction
   // ----------------------------------------
   // arithmetic
   // ----------------------------------------
   always_comb begin
      xfer_left = {3'h0, 5'(XFER_TOTAL - attempted)};
      if (predec) begin
         next_addr = op_addr - size_bytes(size_code);
      end else begin
         next_addr = op_addr + size_bytes(size_code);
      end
   end
endmodule

// file: dv/fault_frame_tb.sv
// bench for the fault frame block: table of fault cases, then clock enable,
// returns, reruns, double fault and a mid-run reset
// assumes one clock domain and inputs driven 2 ns after each rising edge
`timescale 1ns/100ps
module fault_frame_tb;
   import fault_pkg::*;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic clk_sys, rstn, ce, fault, released_write, in_move_xfer;
   logic in_exception, exc_is_bus_fault, exc_short_frame, locked, is_read;
   logic restart_fetch, long_half, step_pend, ebrk_pend, ibrk_pend;
   logic move_predec, move_done, ret_go, rerun_ack;
   logic [1:0] size_left;
   logic [2:0] space;
   logic [4:0] move_attempted;
   logic [15:0] status, exc_status, exc_vector, ret_word, ret_status;
   logic [31:0] fault_addr, out_data, pc, move_addr, postinc_val;
   logic [31:0] exc_pc, exc_ret, ret_addr, ret_data, ret_pc, rerun_rdata;
   logic frame_valid, frame_below, restore_regs, postinc_we, halted;
   logic requeue_step, requeue_ebrk, requeue_ibrk, rerun_req, rerun_read;
   logic refetch, move_resume;
   logic [15:0] frame_word, frame_status, frame_exc_status, frame_exc_vector;
   logic [15:0] rest_status, raw_word;
   logic [31:0] frame_addr, frame_data, frame_pc, frame_exc_pc;
   logic [31:0] frame_exc_ret, postinc_out, rest_addr, rest_data, rest_pc;
   logic [31:0] rerun_wdata;
   logic [7:0] frame_count;
   logic [2:0] rerun_space;
   logic [1:0] rerun_size;
   int err_total, checked, cycles;
   // one fault case: class, pending bits, cycle bits and expected frame
   typedef struct packed {
      logic [2:0] cls;   // released write, move transfer, exception
      logic [2:0] pend;  // step, external break, internal break
      logic [3:0] cyc;   // locked, read, restart fetch, long half
      logic [1:0] sz;
      logic [2:0] fc;
      logic [4:0] att;
      logic pd;
      logic [15:0] word;
      logic [31:0] addr;
      logic [7:0] cnt;
   } row_t;
   localparam row_t ROWS [7] = '{
      '{3'h0, 3'h6, 4'h9, 2'h2, 3'h5, 5'h00, 1'h0, 16'h0935, 32'h1000, 8'h00},
      '{3'h0, 3'h1, 4'h6, 2'h1, 3'h6, 5'h00, 1'h0, 16'h04CE, 32'h1000, 8'h00},
      '{3'h4, 3'h4, 4'hB, 2'h0, 3'h1, 5'h00, 1'h0, 16'h1221, 32'h1000, 8'h00},
      '{3'h2, 3'h7, 4'h8, 2'h2, 3'h2, 5'h03, 1'h0, 16'h5E12, 32'h2002, 8'h0D},
      '{3'h2, 3'h0, 4'h7, 2'h0, 3'h5, 5'h10, 1'h1, 16'h40E5, 32'h1FFC, 8'h00},
      '{3'h5, 3'h5, 4'hA, 2'h1, 3'h7, 5'h00, 1'h0, 16'h944F, 32'h1000, 8'h00},
      '{3'h2, 3'h0, 4'h1, 2'h2, 3'h1, 5'h05, 1'h0, 16'h4231, 32'h2004, 8'h0B}
   };
   // compare macro: every comparison is counted
   `define CHK(g, e) check_val(32'(g), 32'(e), `__LINE__)
   // ----------------------------------------
   // device under test and clock
   // ----------------------------------------
   fault_frame dut (.*);
   // clock toggles every 12.5 ns, half the 25 ns period
   always #12.5 clk_sys = ~clk_sys;
   // hang guard: the whole run needs well under 200 cycles
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         err_total++;
         test_done();
      end
   end
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   // report a mismatch at once and count every comparison
   task automatic check_val(logic [31:0] got, logic [31:0] exp, int ln);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: line %0d got %h want %h",
            $time, ln, got, exp);
      end
   endtask
   // advance one edge and land just after it
   task automatic step;
      @(posedge clk_sys);
      #2;
   endtask
   // verdict and end of run
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // ----------------------------------------
   // stimulus
   // ----------------------------------------
   initial begin
      clk_sys = 0; rstn = 0; ce = 1; fault = 0; released_write = 0;
      in_move_xfer = 0; in_exception = 0; exc_is_bus_fault = 0;
      exc_short_frame = 0; locked = 0; is_read = 0; restart_fetch = 0;
      long_half = 0; size_left = 2'h0; space = 3'h0; step_pend = 0;
      ebrk_pend = 0; ibrk_pend = 0; move_predec = 0; move_done = 0;
      ret_go = 0; rerun_ack = 0; move_attempted = 5'h00;
      status = 16'h2700; exc_status = 16'h2004; exc_vector = 16'h0018;
      ret_word = 16'h0000; ret_status = 16'h2010; fault_addr = 32'h1000;
      out_data = 32'hCAFE0001; pc = 32'h4000; move_addr = 32'h2000;
      postinc_val = 32'h3004; exc_pc = 32'h5000; exc_ret = 32'h5002;
      ret_addr = 32'h6000; ret_data = 32'h1234ABCD; ret_pc = 32'h7000;
      rerun_rdata = 32'hFFFF0000; err_total = 0; checked = 0; cycles = 0;
      repeat (6) @(posedge clk_sys);
      #2;
      `CHK(frame_valid, 0);
      `CHK(halted, 0);
      `CHK(rerun_req, 0);
      rstn = 1;
      step();
      // table of fault classes, one fault every two cycles
      foreach (ROWS[i]) begin
         {released_write, in_move_xfer, in_exception} = ROWS[i].cls;
         exc_short_frame = ROWS[i].cls[0];
         {step_pend, ebrk_pend, ibrk_pend} = ROWS[i].pend;
         {locked, is_read, restart_fetch, long_half} = ROWS[i].cyc;
         size_left = ROWS[i].sz;
         space = ROWS[i].fc;
         move_attempted = ROWS[i].att;
         move_predec = ROWS[i].pd;
         fault = 1;
         step();
         fault = 0;
         `CHK(frame_valid, 1);
         `CHK(frame_word, ROWS[i].word);
         `CHK(frame_addr, ROWS[i].addr);
         `CHK(restore_regs, ROWS[i].cls == 3'h0);
         `CHK(postinc_we, 0);
         `CHK(frame_data, out_data);
         `CHK(frame_pc, pc);
         `CHK(frame_status, status);
         if (ROWS[i].cls == 3'h2) begin
            `CHK(frame_count, ROWS[i].cnt);
         end
         if (ROWS[i].cls[0]) begin
            `CHK(frame_below, 1);
            `CHK(frame_exc_status, exc_status);
            `CHK(frame_exc_vector, exc_vector);
            `CHK(frame_exc_pc, exc_pc);
            `CHK(frame_exc_ret, exc_ret);
         end else begin
            `CHK(frame_below, 0);
         end
         step();
         `CHK(frame_valid, 0);
      end
      {released_write, in_move_xfer, in_exception} = 3'h0;
      exc_short_frame = 0;
      // postincrement write happens only at instruction end
      move_done = 1;
      step();
      move_done = 0;
      `CHK(postinc_we, 1);
      `CHK(postinc_out, postinc_val);
      // held clock enable swallows a fault
      ce = 0;
      fault = 1;
      step();
      step();
      fault = 0;
      ce = 1;
      `CHK(frame_valid, 0);
      // return with rerun, edited to a read, all pending bits set
      ret_word = 16'h1E53;
      ret_go = 1;
      step();
      ret_go = 0;
      `CHK(rerun_req, 1);
      `CHK(rerun_read, 1);
      `CHK(rerun_space, 3'h3);
      `CHK(rerun_size, 2'h2);
      `CHK({requeue_step, requeue_ebrk, requeue_ibrk}, 3'h7);
      `CHK(rest_addr, ret_addr);
      `CHK(rest_data, ret_data);
      `CHK(rest_pc, ret_pc);
      `CHK(rest_status, ret_status);
      `CHK(rerun_wdata, ret_data);
      `CHK(refetch, 0);
      // a fault during the rerun is refused
      fault = 1;
      step();
      fault = 0;
      `CHK(frame_valid, 0);
      `CHK(requeue_step, 0);
      rerun_ack = 1;
      step();
      rerun_ack = 0;
      `CHK(rerun_req, 0);
      `CHK(rest_data, ret_data);
      // handler keeps a long write whole: back up 2, widen size to long
      raw_word = 16'h0231;
      ret_addr = (raw_word[LONG_B] && raw_word[SIZE_LO +: 2] != SIZE_LONG)
         ? 32'h1000 : 32'h1002;
      ret_word = {raw_word[15:5], SIZE_LONG, raw_word[2:0]};
      ret_go = 1;
      step();
      ret_go = 0;
      `CHK(rerun_size, SIZE_LONG);
      `CHK(rest_addr, 32'h1000);
      `CHK(rerun_read, 0);
      `CHK(rerun_space, 3'h1);
      rerun_ack = 1;
      step();
      rerun_ack = 0;
      `CHK(rerun_req, 0);
      // plain return of a restartable frame refetches
      ret_word = 16'h0000;
      ret_go = 1;
      step();
      `CHK(refetch, 1);
      `CHK(rerun_req, 0);
      `CHK(move_resume, 0);
      // back to back: return of a move frame resumes the move
      ret_word = 16'h4000;
      step();
      ret_go = 0;
      `CHK(move_resume, 1);
      `CHK(refetch, 0);
      step();
      // second bus fault while processing a bus error halts
      in_exception = 1;
      exc_is_bus_fault = 1;
      fault = 1;
      step();
      fault = 0;
      in_exception = 0;
      exc_is_bus_fault = 0;
      `CHK(halted, 1);
      `CHK(frame_valid, 0);
      fault = 1;
      step();
      fault = 0;
      `CHK(halted, 1);
      `CHK(frame_valid, 0);
      // reset in mid-run clears the halt
      rstn = 0;
      #1;
      `CHK(halted, 0);
      step();
      rstn = 1;
      step();
      `CHK(halted, 0);
      `CHK(frame_valid, 0);
      `CHK(rerun_req, 0);
      `CHK(frame_word, WORD_RST);
      test_done();
   end
endmodule
